// >>> core/scp_serial_port.sv
// Serial command port: command decode, configuration and DAC registers
//
// What this block does
// - Load-DAC low makes DAC registers transparent; input sampled on the reference clock via two-stage sync.
// - Serial interface acts only while chip select is low.
// - Serial output is released (enable low) whenever chip select is high.
// - Wake-select low wakes DACs at zero scale, high at full scale.
// - Works with serial clock idling low or high (CPOL equals CPHA).
// - Input bits captured on each falling serial clock edge while selected.
// - Clock modes 00, 01, 10 change output on falling edge.
// - Clock mode 11 changes output on rising edge.
// - Bipolar differential and temperature results are two's complement, others binary.
// - Chip select falling starts a new transaction.
// - Each transaction starts with an 8-bit command, MSB first.
// - Command decides length of 8, 16 or 24 bits and target.
// - Chip select high resets bit and byte position.
// - Conversion command sets channel, scan mode and temperature request.
// - Setup command sets clock mode, reference, polarity; optional byte loads mode register.
// - DAC write is 0001XXXX then two bytes: selector and data.
// - GPIO write is command byte plus exactly one data byte.
// - Variant without GPIOs ignores GPIO commands entirely.
// - Four general-purpose pins, each input or output.
// - End-of-conversion goes low once result is valid.
`timescale 1ns/1ns
module scp_serial_port #(
   parameter bit HAS_GPIO = 1'b1
) (
   input  wire logic                                       REF_CLK_I,
   input  wire logic                                       RSTN_I,
   input  wire logic                                       CS_N_I,
   input  wire logic                                       SCLK_I,
   input  wire logic                                       DIN_I,
   input  wire logic                                       LOAD_DAC_N_I,
   input  wire logic                                       DAC_WAKE_SELECT_I,
   input  wire logic [scp_pkg::ADC_W-1:0]                  ADC_RESULT_I,
   input  wire logic                                       ADC_RESULT_VALID_I,
   input  wire logic [scp_pkg::NUM_GP-1:0]                 GP_PIN_I,
   output logic      [scp_pkg::NUM_GP-1:0]                 GP_PIN_O,
   output logic      [scp_pkg::NUM_GP-1:0]                 GP_PIN_OE_O,
   output logic                                            DOUT_O,
   output logic                                            DOUT_OE_O,
   output logic                                            EOC_N_O,
   output logic      [7:0]                                 CONV_REG_O,
   output logic                                            CONV_REQ_O,
   output logic      [5:0]                                 SETUP_REG_O,
   output logic      [7:0]                                 UNI_MODE_O,
   output logic      [7:0]                                 BIP_MODE_O,
   output logic      [scp_pkg::NUM_DAC-1:0][scp_pkg::DAC_W-1:0] DAC_CODE_O
);
   scp_pkg::scp_state_t st_reg;
   scp_pkg::scp_state_t st_next;

   logic       sclk_s;
   logic       cs_s;
   logic       din_s;
   logic       fall;
   logic       rise;
   logic       cs_fall;
   logic [7:0] byte_in;
   logic       byte_done;
   logic       mode11;
   logic       bipolar_diff;
   logic [2:0] dac_sel;
   logic [scp_pkg::DAC_W-1:0] dac_val;
   logic [15:0] result_fmt;

   // Second stage only; first stage feeds nothing else
   assign sclk_s       = st_reg.pins.sclk_sync[1];
   assign cs_s         = st_reg.pins.cs_sync[1];
   assign din_s        = st_reg.pins.din_sync[1];
   assign fall         = st_reg.pins.sclk_prev & ~sclk_s & ~cs_s;
   assign rise         = ~st_reg.pins.sclk_prev & sclk_s & ~cs_s;
   assign cs_fall      = st_reg.pins.cs_prev & ~cs_s;
   assign byte_in      = {st_reg.shift[6:0], din_s};
   assign byte_done    = fall && (st_reg.bit_cnt == scp_pkg::BITS_PER_BYTE);
   assign mode11       = (st_reg.setup[scp_pkg::SETUP_CKSEL_MSB:scp_pkg::SETUP_CKSEL_LSB] == scp_pkg::CKSEL_MODE_11);
   assign bipolar_diff = st_reg.setup[scp_pkg::SETUP_DIFF_MSB:scp_pkg::SETUP_DIFF_LSB] != 2'h0
                         && st_reg.bip_mode[scp_pkg::DIFF_SEL_BIT];
   assign dac_sel      = st_reg.byte1[6:4];
   assign dac_val      = {st_reg.byte1[3:0], byte_in[7:2]};

   // Bipolar differential and temperature codes are offset binary; flipping MSB gives two's complement
   always_comb begin
      result_fmt = {6'h00, ADC_RESULT_I};
      if (bipolar_diff || st_reg.conv[scp_pkg::CONV_TEMP_BIT]) begin
         result_fmt = {{6{~ADC_RESULT_I[scp_pkg::ADC_W-1]}}, ~ADC_RESULT_I[scp_pkg::ADC_W-1],
                       ADC_RESULT_I[scp_pkg::ADC_W-2:0]};
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.pins.sclk_sync = {st_reg.pins.sclk_sync[0], SCLK_I};
      st_next.pins.cs_sync   = {st_reg.pins.cs_sync[0], CS_N_I};
      st_next.pins.din_sync  = {st_reg.pins.din_sync[0], DIN_I};
      st_next.pins.load_dac_n_sync = {st_reg.pins.load_dac_n_sync[0], LOAD_DAC_N_I};
      st_next.pins.wake_sync = {st_reg.pins.wake_sync[0], DAC_WAKE_SELECT_I};
      st_next.pins.sclk_prev = sclk_s;
      st_next.pins.cs_prev   = cs_s;
      st_next.conv_req       = 1'b0;

      // Strap caught once, only after it has passed both sync stages
      if (st_reg.pins.boot_cnt != scp_pkg::WAKE_WAIT) begin
         st_next.pins.boot_cnt = st_reg.pins.boot_cnt + 2'h1;
      end else if (!st_reg.wake_taken) begin
         st_next.wake_taken = 1'b1;
         for (int i = 0; i < scp_pkg::NUM_DAC; i++) begin
            st_next.dac_input[i] = st_reg.pins.wake_sync[1] ? scp_pkg::DAC_FULL : scp_pkg::DAC_ZERO;
            st_next.dac_out[i]   = st_reg.pins.wake_sync[1] ? scp_pkg::DAC_FULL : scp_pkg::DAC_ZERO;
         end
      end

      if (cs_s) begin
         st_next.phase   = scp_pkg::PH_CMD;
         st_next.bit_cnt = 3'h0;
         st_next.shift   = 8'h00;
         st_next.dout_en = 1'b0;
      end else begin
         st_next.dout_en = 1'b1;
         if (cs_fall) begin
            st_next.phase   = scp_pkg::PH_CMD;
            st_next.bit_cnt = 3'h0;
            st_next.dout    = st_reg.tx[15];
         end
         // Output shifts on rising edge in mode 11, falling otherwise
         if ((mode11 && rise) || (!mode11 && fall)) begin
            st_next.dout = st_reg.tx[14];
            st_next.tx   = {st_reg.tx[14:0], 1'b0};
            st_next.eoc_n = 1'b1;
         end
         if (fall) begin
            st_next.shift   = byte_in;
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
         end
         if (byte_done) begin
            unique case (st_reg.phase)
               scp_pkg::PH_CMD: begin
                  st_next.cmd   = byte_in;
                  st_next.phase = scp_pkg::PH_DONE;
                  st_next.extra = 2'h0;
                  // Decode on eighth edge; length and target fixed here
                  if ((byte_in & scp_pkg::CMD_CONV_MASK) != 8'h00) begin
                     st_next.conv     = byte_in;
                     st_next.conv_req = 1'b1;
                     st_next.target   = scp_pkg::TGT_ADC;
                  end else if ((byte_in & scp_pkg::CMD_SETUP_MASK) != 8'h00) begin
                     st_next.setup  = byte_in[5:0];
                     st_next.target = scp_pkg::TGT_ADC;
                     if (byte_in[5:4] != 2'h0 || byte_in[1:0] != 2'h0) begin
                        st_next.phase = scp_pkg::PH_DATA1;
                        st_next.extra = 2'h1;
                     end
                  end else if (byte_in[7:4] == scp_pkg::CMD_DAC_NIB) begin
                     st_next.target = scp_pkg::TGT_DAC;
                     st_next.phase  = scp_pkg::PH_DATA1;
                     st_next.extra  = 2'h2;
                  end else if (byte_in[3:0] == scp_pkg::SUB_GPIO_CFG || byte_in[3:0] == scp_pkg::SUB_GPIO_WR) begin
                     // Without GPIOs the command is simply dropped
                     if (HAS_GPIO) begin
                        st_next.target = scp_pkg::TGT_GPIO;
                        st_next.phase  = scp_pkg::PH_DATA1;
                        st_next.extra  = 2'h1;
                     end
                  end else if (byte_in[3:0] == scp_pkg::SUB_GPIO_RD && HAS_GPIO) begin
                     st_next.tx = {GP_PIN_I, 12'h000};
                  end
               end
               scp_pkg::PH_DATA1: begin
                  st_next.byte1 = byte_in;
                  if (st_reg.extra == 2'h1) begin
                     st_next.phase = scp_pkg::PH_DONE;
                     if (st_reg.target == scp_pkg::TGT_GPIO) begin
                        if (st_reg.cmd[3:0] == scp_pkg::SUB_GPIO_CFG) begin
                           st_next.gp_dir = byte_in[3:0];
                        end else begin
                           st_next.gp_out = byte_in[3:0];
                        end
                     end else if (st_reg.cmd[1:0] != 2'h0) begin
                        st_next.bip_mode = byte_in;
                     end else begin
                        st_next.uni_mode = byte_in;
                     end
                  end else begin
                     st_next.phase = scp_pkg::PH_DATA2;
                  end
               end
               scp_pkg::PH_DATA2: begin
                  // Commit only once the full third byte is in
                  st_next.dac_input[dac_sel] = dac_val;
                  st_next.phase = scp_pkg::PH_DONE;
               end
               scp_pkg::PH_DONE: begin
                  st_next.phase = scp_pkg::PH_DONE; // Extra bytes ignored
               end
            endcase
         end
      end

      // New result wins over a shift in the same cycle
      if (ADC_RESULT_VALID_I) begin
         st_next.tx    = result_fmt;
         st_next.eoc_n = 1'b0;
      end

      // Level-sensitive transfer mirrors a transparent latch
      if (!st_reg.pins.load_dac_n_sync[1]) begin
         st_next.dac_out = st_next.dac_input;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st_reg <= '0;
         st_reg.pins.cs_sync   <= 2'h3;
         st_reg.pins.cs_prev   <= 1'b1;
         st_reg.pins.load_dac_n_sync <= 2'h3;
         st_reg.eoc_n          <= 1'b1;
         st_reg.phase          <= scp_pkg::PH_CMD;
         st_reg.target         <= scp_pkg::TGT_NONE;
         st_reg.conv           <= scp_pkg::CONV_RST;
         st_reg.setup          <= scp_pkg::SETUP_RST;
         st_reg.uni_mode       <= scp_pkg::MODE_RST;
         st_reg.bip_mode       <= scp_pkg::MODE_RST;
         st_reg.gp_dir         <= scp_pkg::GP_RST;
         st_reg.gp_out         <= scp_pkg::GP_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign GP_PIN_O    = st_reg.gp_out;
   assign GP_PIN_OE_O = st_reg.gp_dir;
   assign DOUT_O      = st_reg.dout;
   assign DOUT_OE_O   = st_reg.dout_en;
   assign EOC_N_O     = st_reg.eoc_n;
   assign CONV_REG_O  = st_reg.conv;
   assign CONV_REQ_O  = st_reg.conv_req;
   assign SETUP_REG_O = st_reg.setup;
   assign UNI_MODE_O  = st_reg.uni_mode;
   assign BIP_MODE_O  = st_reg.bip_mode;
   assign DAC_CODE_O  = st_reg.dac_out;
endmodule : scp_serial_port

// >>> core/scp_pkg.sv
// Package for the serial command port: constants and carrier types
package scp_pkg;
   // Command byte prefixes (upper nibble decides target, low nibble for GPIO)
   localparam logic [3:0] CMD_DAC_NIB     = 4'h1;
   localparam logic [7:0] CMD_CONV_MASK   = 8'h80;
   localparam logic [7:0] CMD_SETUP_MASK  = 8'h40;
   localparam logic [3:0] CMD_GPIO_CFG    = 4'h0;
   localparam logic [3:0] CMD_GPIO_NIB_LO = 4'h0;
   // Low nibble codes under upper nibble 0000
   localparam logic [3:0] SUB_GPIO_CFG    = 4'h3;
   localparam logic [3:0] SUB_GPIO_WR     = 4'h4;
   localparam logic [3:0] SUB_GPIO_RD     = 4'h5;
   // Field positions
   localparam int         SETUP_CKSEL_MSB = 5;
   localparam int         SETUP_CKSEL_LSB = 4;
   localparam int         SETUP_REF_MSB   = 3;
   localparam int         SETUP_REF_LSB   = 2;
   localparam int         SETUP_DIFF_MSB  = 1;
   localparam int         SETUP_DIFF_LSB  = 0;
   localparam int         CONV_CH_MSB     = 6;
   localparam int         CONV_CH_LSB     = 3;
   localparam int         CONV_SCAN_MSB   = 2;
   localparam int         CONV_SCAN_LSB   = 1;
   localparam int         CONV_TEMP_BIT   = 0;
   localparam int         DIFF_SEL_BIT    = 0;
   // Widths
   localparam int         NUM_GP          = 4;
   localparam int         NUM_DAC         = 8;
   localparam int         DAC_W           = 10;
   localparam int         ADC_W           = 10;
   localparam logic [2:0] BITS_PER_BYTE   = 3'h7;
   localparam logic [1:0] CKSEL_MODE_11   = 2'h3;
   // Clocks after reset before the strap has crossed both sync stages
   localparam logic [1:0] WAKE_WAIT       = 2'h3;
   // Reset values
   localparam logic [7:0] CONV_RST        = 8'h00;
   localparam logic [5:0] SETUP_RST       = 6'h00;
   localparam logic [7:0] MODE_RST        = 8'h00;
   localparam logic [3:0] GP_RST          = 4'h0;
   localparam logic [DAC_W-1:0] DAC_ZERO  = 10'h000;
   localparam logic [DAC_W-1:0] DAC_FULL  = 10'h3FF;

   typedef enum logic [1:0] {
      TGT_NONE,
      TGT_ADC,
      TGT_DAC,
      TGT_GPIO
   } scp_target_t;

   typedef enum logic [1:0] {
      PH_CMD,
      PH_DATA1,
      PH_DATA2,
      PH_DONE
   } scp_phase_t;

   typedef struct packed {
      logic [1:0] sclk_sync;
      logic [1:0] cs_sync;
      logic [1:0] din_sync;
      logic [1:0] load_dac_n_sync;
      logic [1:0] wake_sync;
      logic       sclk_prev;
      logic       cs_prev;
      logic [1:0] boot_cnt;
   } scp_pins_t;

   typedef struct packed {
      scp_pins_t                         pins;
      scp_phase_t                        phase;
      scp_target_t                       target;
      logic [2:0]                        bit_cnt;
      logic [7:0]                        shift;
      logic [7:0]                        cmd;
      logic [7:0]                        byte1;
      logic [1:0]                        extra;
      logic [7:0]                        conv;
      logic [5:0]                        setup;
      logic [7:0]                        uni_mode;
      logic [7:0]                        bip_mode;
      logic [3:0]                        gp_dir;
      logic [3:0]                        gp_out;
      logic [NUM_DAC-1:0][DAC_W-1:0]     dac_input;
      logic [NUM_DAC-1:0][DAC_W-1:0]     dac_out;
      logic                              wake_taken;
      logic [15:0]                       tx;
      logic                              dout;
      logic                              dout_en;
      logic                              eoc_n;
      logic                              conv_req;
   } scp_state_t;
endpackage : scp_pkg

// >>> bench/scp_spi_master.sv
// Bus master model that drives the serial command port
`timescale 1ns/1ns
module scp_spi_master (
   input  wire logic clk_i,
   input  wire logic dout_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      din_o
);
   logic [23:0] rx;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o  = 1'b0;
      rx     = 24'h000000;
   end
   // Half serial period of 4 clocks, 160 ns
   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask : half
   // Bits change on rising edges so the falling capture edge never races them
   task automatic xfer(input logic [23:0] word, input int nbits, input logic cpol);
      logic [23:0] w;
      w = word;
      @(posedge clk_i);
      sclk_o <= cpol;
      half();
      cs_n_o <= 1'b0;
      if (cpol) begin
         din_o <= w[23];
         w = w << 1;
      end
      half();
      half();
      for (int i = 0; i < 2 * nbits; i++) begin
         if (!sclk_o) begin
            din_o <= w[23];
            w = w << 1;
            rx <= {rx[22:0], dout_i};
         end
         sclk_o <= ~sclk_o;
         half();
      end
      cs_n_o <= 1'b1;
      din_o  <= ~din_o;
      half();
   endtask : xfer
endmodule : scp_spi_master

// >>> bench/scp_serial_port_props.sv
// Checker for the serial command port
`timescale 1ns/1ns
module scp_serial_port_props (
   input wire logic                                            REF_CLK_I,
   input wire logic                                            RSTN_I,
   input wire logic                                            CS_N_I,
   input wire logic                                            LOAD_DAC_N_I,
   input wire logic                                            ADC_RESULT_VALID_I,
   input wire logic                                            DOUT_O,
   input wire logic                                            DOUT_OE_O,
   input wire logic                                            EOC_N_O,
   input wire logic [7:0]                                      CONV_REG_O,
   input wire logic                                            CONV_REQ_O,
   input wire logic [5:0]                                      SETUP_REG_O,
   input wire logic [scp_pkg::NUM_DAC-1:0][scp_pkg::DAC_W-1:0] DAC_CODE_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // Uptime counter keeps the wake load out of the hold check
   logic [3:0] up_reg;
   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
      if (!RSTN_I) up_reg <= 4'h0;
      else if (up_reg != 4'hF) up_reg <= up_reg + 4'h1;
   oe_release_a: assert property (CS_N_I [*6] |-> !DOUT_OE_O) else $error("output driven while deselected");
   oe_drive_a: assert property (!CS_N_I [*6] |-> DOUT_OE_O) else $error("output not driven while selected");
   req_pulse_a: assert property (CONV_REQ_O |=> !CONV_REQ_O && CONV_REG_O[7])
      else $error("conversion request not a single pulse");
   req_selected_a: assert property (CONV_REQ_O |-> !$past(CS_N_I, 2))
      else $error("conversion request without selection");
   eoc_low_a: assert property (ADC_RESULT_VALID_I |-> ##[1:2] !EOC_N_O)
      else $error("end of conversion not flagged");
   cfg_hold_a: assert property (CS_N_I [*6] |-> $stable({CONV_REG_O, SETUP_REG_O}))
      else $error("configuration changed while deselected");
   dout_quiet_a: assert property ((CS_N_I && !ADC_RESULT_VALID_I) [*6] |-> $stable(DOUT_O))
      else $error("serial output moved while deselected");
   dac_hold_a: assert property ((LOAD_DAC_N_I && up_reg == 4'hF) [*4] |-> $stable(DAC_CODE_O))
      else $error("dac codes moved while load held high");
endmodule : scp_serial_port_props
bind scp_serial_port scp_serial_port_props u_props (
   .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .CS_N_I(CS_N_I), .LOAD_DAC_N_I(LOAD_DAC_N_I),
   .ADC_RESULT_VALID_I(ADC_RESULT_VALID_I), .DOUT_O(DOUT_O), .DOUT_OE_O(DOUT_OE_O), .EOC_N_O(EOC_N_O),
   .CONV_REG_O(CONV_REG_O), .CONV_REQ_O(CONV_REQ_O), .SETUP_REG_O(SETUP_REG_O), .DAC_CODE_O(DAC_CODE_O)
);

// >>> bench/scp_serial_port_test.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ns
`define CMP(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module scp_serial_port_test;
   logic                                            ref_clk, rstn, load_dac_n_n, wake, adc_vld, cs_n, sclk, din;
   logic                                            dout, dout_oe, eoc_n, conv_req;
   logic [9:0]                                      adc_res, d;
   logic [3:0]                                      gp_in, gp_out, gp_oe, dir, val;
   logic [7:0]                                      conv, uni, bip, c, m;
   logic [5:0]                                      setup;
   logic [2:0]                                      idx;
   logic [scp_pkg::NUM_DAC-1:0][scp_pkg::DAC_W-1:0] dac;
   int                                              fails, checks_done, req_seen, n0;
   scp_serial_port uut (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .CS_N_I(cs_n), .SCLK_I(sclk), .DIN_I(din),
      .LOAD_DAC_N_I(load_dac_n_n), .DAC_WAKE_SELECT_I(wake), .ADC_RESULT_I(adc_res), .ADC_RESULT_VALID_I(adc_vld),
      .GP_PIN_I(gp_in), .GP_PIN_O(gp_out), .GP_PIN_OE_O(gp_oe), .DOUT_O(dout), .DOUT_OE_O(dout_oe),
      .EOC_N_O(eoc_n), .CONV_REG_O(conv), .CONV_REQ_O(conv_req), .SETUP_REG_O(setup), .UNI_MODE_O(uni),
      .BIP_MODE_O(bip), .DAC_CODE_O(dac));
   scp_spi_master mst (.clk_i(ref_clk), .dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (conv_req === 1'b1) req_seen++;
   // Second byte needed only when clock mode or polarity bits are set
   function automatic logic needs_mode(input logic [7:0] cmd);
      return cmd[5:4] != 2'h0 || cmd[1:0] != 2'h0;
   endfunction : needs_mode
   task automatic wr(input logic [23:0] w, input int n);
      mst.xfer(w, n, 1'($urandom));
      repeat (4) @(posedge ref_clk);
   endtask : wr
   task automatic do_reset(input logic w);
      rstn <= 1'b0;
      wake <= w;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < scp_pkg::NUM_DAC; i++) `CMP("wake", w ? scp_pkg::DAC_FULL : scp_pkg::DAC_ZERO, dac[i])
   endtask : do_reset
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      end_of_test();
   end
   initial begin
      {rstn, load_dac_n_n, wake, adc_vld} = 4'h4;
      adc_res = 10'h000;
      gp_in = 4'h0;
      void'($urandom(32'hD5C6));
      do_reset(1'b0);
      do_reset(1'b1);
      gp_in <= 4'($urandom);
      $display("reset test done");
      for (int k = 0; k < 6; k++) begin
         c = (k == 0) ? 8'h7F : {2'b01, 6'($urandom)};
         m = 8'($urandom);
         wr({c, m, 8'h00}, needs_mode(c) ? 16 : 8);
         `CMP("setup", c[5:0], setup)
         if (needs_mode(c)) `CMP("mode", m, c[1:0] != 2'h0 ? bip : uni)
      end
      for (int k = 0; k < 4; k++) begin
         c = {1'b1, 7'($urandom)};
         n0 = req_seen;
         wr({c, 16'h0000}, 8);
         `CMP("conv", c, conv)
         `CMP("conv req", n0 + 1, req_seen)
      end
      $display("config test done");
      for (int k = 0; k < 3; k++) begin
         idx = 3'($urandom);
         d = (k == 0) ? scp_pkg::DAC_FULL : 10'($urandom);
         m = dac[idx][7:0];
         wr({4'h1, 4'($urandom), 1'b0, idx, d, 2'b00}, 24);
         `CMP("dac held", m, dac[idx][7:0])
         load_dac_n_n <= 1'b0;
         repeat (6) @(posedge ref_clk);
         `CMP("dac load", d, dac[idx])
         wr({8'h10, 1'b0, idx, ~d, 2'b00}, 20);
         `CMP("dac partial", d, dac[idx])
         load_dac_n_n <= 1'b1;
      end
      $display("dac test done");
      dir = 4'($urandom);
      val = 4'($urandom);
      wr({8'h03, 4'h0, dir, 8'h00}, 16);
      wr({8'h04, 4'h0, val, 8'($urandom)}, 24);
      `CMP("gp dir", dir, gp_oe)
      `CMP("gp out", val, gp_out)
      $display("gpio test done");
      wr(24'h400000, 8);
      wr(24'h800000, 8);
      d = 10'($urandom);
      adc_res <= d;
      adc_vld <= 1'b1;
      @(posedge ref_clk);
      adc_vld <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CMP("eoc low", 1'b0, eoc_n)
      mst.xfer(24'h000000, 16, 1'b0);
      `CMP("result", {6'h00, d}, mst.rx[15:0])
      `CMP("eoc high", 1'b1, eoc_n)
      $display("readout test done");
      end_of_test();
   end
endmodule : scp_serial_port_test
